// File: adc_sample_packetizer_tb.sv
`timescale 1ns/1ps
module adc_sample_packetizer_tb
    import asp_pkg::*;
;
    logic        clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0;
    logic        pwrite = 1'b0, pready, pslverr, irq, adc_cal, adc_on;
    logic [7:0]  paddr = 8'h0;
    logic [31:0] pwdata = 32'h0, prdata;
    logic [2:0]  adc_sel;
    logic [11:0] adc_result;
    int          n_fail = 0, cmp_count = 0;
    logic [23:0] dst [8] = '{6: 24'habcdef, 7: 24'h123456, default: 24'h0};
    logic [1:0]  wc [5] = '{2'h1, 2'h3, 2'h0, 2'h2, 2'h0};
    logic [7:0]  sp [5] = '{8'h1, 8'h1, 8'h2, 8'h1, 8'h0};
    int          nbt [5] = '{2, 4, 1, 1, 1};
    // analog mux stand-in: input number shows in the top result bits
    assign adc_result = adc_cal ? 12'hccc : {adc_sel, 9'h05a};
    always #2.5 clk = ~clk;
    asp_link_if link ();
    asp_device asp_device_inst (.clk(clk), .rst_b(rst_b), .link(link),
        .adc_result(adc_result), .adc_sel(adc_sel), .adc_cal(adc_cal),
        .adc_on(adc_on));
    asp_ctrl asp_ctrl_inst (.clk(clk), .rst_b(rst_b), .link(link),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq));
    asp_assertions asp_assertions_inst (.clk(clk), .rst_b(rst_b),
        .reg_req(link.reg_req), .reg_wr(link.reg_wr),
        .reg_addr(link.reg_addr), .reg_wdata(link.reg_wdata),
        .reg_ack(link.reg_ack), .reg_rdata(link.reg_rdata),
        .samp(link.samp), .tok_valid(link.tok_valid),
        .tok_end(link.tok_end), .tok_data(link.tok_data),
        .tok_dest(link.tok_dest), .tok_ready(link.tok_ready));
    task automatic wrap_up();
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic tmo(input bit t);
        if (t) begin
            n_fail++;
            wrap_up();
        end
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            n_fail++;
            $display("FAIL %0t seen %h expected %h", $time, s, e);
        end
    endtask
    // one apb transfer; an edge passes after release so calls can chain
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        int i;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge clk);
            if (pready === 1'b1)
                break;
        end
        q = prdata;
        tmo(i == 50);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        apb(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        apb(1'b0, a, 32'h0, q);
    endtask
    // device register access through the controller, polled on busy
    task automatic dev(input logic w, input logic [5:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        int i;
        wr(C_WDATA_OFS, d);
        wr(C_CMD_OFS, {1'b1, 22'h0, w, 2'h0, a});
        for (i = 0; i < 20; i++) begin
            rd(C_CMD_OFS, q);
            if (q[CMD_GO_BIT] === 1'b0)
                break;
        end
        tmo(i == 20);
        rd(C_RDATA_OFS, q);
    endtask
    task automatic pulse();
        wr(C_PULSE_OFS, 32'h1);
        wr(C_PULSE_OFS, 32'h0);
    endtask
    task automatic get(output logic [31:0] q);
        int i;
        for (i = 0; i < 40; i++) begin
            rd(C_RXD_OFS, q);
            if (q[RX_FULL_BIT] === 1'b1)
                break;
        end
        tmo(i == 40);
    endtask
    // one sample: input from top bits, then dest and every byte
    task automatic sample(input int n, output logic [2:0] k);
        logic [31:0] q, t, word;
        get(q);
        k = q[7:5];
        rd(C_RXDST_OFS, t);
        chk(t[23:0], dst[k]);
        word = {k, 9'h05a, 20'h0};
        for (int i = 0; i < n; i++) begin
            if (i > 0)
                get(q);
            chk(q[8:0], {1'b0, word[31-8*i -: 8]});
        end
    endtask
    initial begin
        logic [31:0] q;
        logic [2:0]  k, k0;
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        dev(1'b0, 6'h18, 32'h0, q);
        chk(q, 32'h0);
        dev(1'b0, GEN_OFS, 32'h0, q);
        chk(q, 32'h0001_0100);
        rd(8'h40, q);
        chk(q, 32'h0);
        chk(pslverr, 1'b0);
        // routes programmed while disabled; access-done interrupt
        wr(C_IMASK_OFS, 32'h1);
        dev(1'b1, 6'h18, {dst[6], 8'h01}, q);
        dev(1'b1, 6'h1c, {dst[7], 8'h01}, q);
        chk(irq, 1'b1);
        wr(C_ISTAT_OFS, 32'h7);
        // irq is registered after the status, so it falls one edge later
        @(posedge clk);
        chk(irq, 1'b0);
        wr(C_IMASK_OFS, 32'h0);
        dev(1'b0, 6'h18, 32'h0, q);
        chk(q, {dst[6], 8'h01});
        chk(irq, 1'b0);
        $display("test reset, routes and interrupt done");
        // each width and count, re-enabled so calibration restarts
        for (int e = 0; e < 5; e++) begin
            dev(1'b1, GEN_OFS, {14'h0, wc[e], sp[e], 8'h00}, q);
            chk(adc_on, 1'b0);
            dev(1'b1, GEN_OFS, {14'h0, wc[e], sp[e], 8'h01}, q);
            chk(adc_on, 1'b1);
            dev(1'b1, 6'h18, 32'hffff_ff00, q);
            repeat (6) pulse();
            rd(C_RXD_OFS, q);
            chk(q[31], 1'b0);
            for (int s = 0; s < (sp[e] == 8'h0 ? 1 : sp[e]); s++) begin
                pulse();
                sample(nbt[e], k);
                if (s > 0)
                    chk(k != k0, 1'b1);
                k0 = k;
            end
            if (sp[e] == 8'h0) begin
                rd(C_RXD_OFS, q);
                chk(q[31], 1'b0);
                dev(1'b0, GEN_OFS, 32'h0, q);
            end
            get(q);
            chk(q[8], 1'b1);
            $display("test width %0d count %0d done", wc[e], sp[e]);
        end
        dev(1'b0, 6'h18, 32'h0, q);
        chk(q, {dst[6], 8'h01});
        // holder left full so the next pulse finds a sample unsent
        dev(1'b1, GEN_OFS, 32'h0000_0100, q);
        dev(1'b1, GEN_OFS, 32'h0000_0101, q);
        repeat (8) pulse();
        dev(1'b0, GEN_OFS, 32'h0, q);
        chk(q[24], 1'b1);
        dev(1'b0, GEN_OFS, 32'h0, q);
        chk(q[24], 1'b0);
        get(q);
        get(q);
        chk(q[8], 1'b1);
        // calibration reference; first sample after the switch read but not checked
        dev(1'b1, GEN_OFS, 32'h0000_0103, q);
        chk(adc_cal, 1'b1);
        pulse();
        get(q);
        get(q);
        pulse();
        get(q);
        chk(q[8:0], 9'h0cc);
        get(q);
        $display("test drop and calibration done");
        wrap_up();
    end
endmodule // adc_sample_packetizer_tb

// File: asp_assertions.sv
`timescale 1ns/1ps
module asp_assertions
    import asp_pkg::*;
(
    input wire logic        clk,
    input wire logic        rst_b,
    input wire logic        reg_req,
    input wire logic        reg_wr,
    input wire logic [5:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_ack,
    input wire logic [31:0] reg_rdata,
    input wire logic        samp,
    input wire logic        tok_valid,
    input wire logic        tok_end,
    input wire logic [7:0]  tok_data,
    input wire logic [23:0] tok_dest,
    input wire logic        tok_ready
);
    logic       en_h;
    logic       sd;
    logic [7:0] ren;
    logic [7:0] spp_h;
    logic [1:0] w_h;
    logic [2:0] cnt;
    logic [9:0] bcnt;
    logic [9:0] nb;
    wire        wa = reg_req && reg_wr && reg_ack;
    assign nb = (w_h == W_32) ? 10'h4 : (w_h == W_16) ? 10'h2 : 10'h1;
    // shadow of what was written over the link; ignores frozen writes
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            en_h  <= 1'b0;
            ren   <= 8'h0;
            w_h   <= WIDTH_RST;
            spp_h <= SPP_RST;
        end else if (wa && reg_addr == GEN_OFS) begin
            en_h  <= reg_wdata[0];
            w_h   <= reg_wdata[17:16];
            spp_h <= reg_wdata[15:8];
        end else if (wa && !en_h && reg_addr < GEN_OFS) begin
            ren[reg_addr[4:2]] <= reg_wdata[0];
        end
    end
    // pulses since enable, saturating; any disable zeroes it
    always_ff @(posedge clk) begin
        sd <= samp;
        if (!rst_b || !en_h)
            cnt <= 3'h0;
        else if (samp && !sd && cnt != 3'h7)
            cnt <= cnt + 3'h1;
    end
    // sample bytes handed over in the open packet
    always_ff @(posedge clk) begin
        if (!rst_b || (tok_valid && tok_ready && tok_end))
            bcnt <= 10'h0;
        else if (tok_valid && tok_ready)
            bcnt <= bcnt + 10'h1;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    AST_ACK_ONE: assert property (reg_req && !reg_ack |=> reg_ack)
        else $error("device access not answered in one cycle");
    AST_REQ_HELD: assert property (reg_req && !reg_ack |=> reg_req
        && $stable(reg_addr) && $stable(reg_wr) && $stable(reg_wdata))
        else $error("device request changed before answer");
    AST_RDATA_HOLD: assert property (!reg_ack |-> $stable(reg_rdata))
        else $error("read data moved without an answer");
    AST_TOK_HOLD: assert property (tok_valid && !tok_ready
        |=> tok_valid && $stable(tok_data) && $stable(tok_end)
        && $stable(tok_dest))
        else $error("token changed while stalled");
    AST_CAL_QUIET: assert property ($rose(tok_valid) && !tok_end
        |-> cnt == 3'h7)
        else $error("sample sent during calibration pulses");
    AST_SAMPLE_SOON: assert property (en_h && cnt >= 3'h6 && samp
        && !sd && !tok_valid && ren != 8'h0 |-> ##[1:3] tok_valid)
        else $error("pulse after calibration gave no sample");
    AST_PKT_LEN: assert property (tok_valid && tok_ready
        && tok_end && spp_h != 8'h0 |-> bcnt == nb * spp_h)
        else $error("packet length wrong for width and count");
    AST_END_ACCESS: assert property (spp_h == 8'h0 && bcnt != 10'h0
        && !tok_valid && reg_ack |-> ##[1:4] (tok_valid && tok_end))
        else $error("open packet not closed by access");
endmodule // asp_assertions

// File: asp_ctrl.sv
`timescale 1ns/1ps
module asp_ctrl
    import asp_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_b,
    asp_link_if.ctl          link,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output wire logic [31:0] prdata,
    output wire logic        pready,
    output wire logic        pslverr,
    output wire logic        irq
);
    logic             pready_reg;
    logic [31:0]      prdata_reg;
    logic             req_reg;
    logic             cmd_wr_reg;
    logic [5:0]       cmd_addr_reg;
    logic [31:0]      wdata_reg;
    logic [31:0]      rdata_reg;
    logic             samp_reg;
    logic             rx_free_reg;
    logic [7:0]       rx_data_reg;
    logic             rx_end_reg;
    logic [23:0]      rx_dest_reg;
    logic [INT_W-1:0] istat_reg;
    logic [INT_W-1:0] imask_reg;
    logic             irq_reg;

    logic             take;
    logic             done;
    logic             wdone;
    logic             rx_hs;
    logic             pop;
    logic [INT_W-1:0] ev;

    // two-cycle access phase: pready rises one edge after penable
    assign take  = psel & penable & ~pready_reg;
    assign done  = psel & penable & pready_reg;
    assign wdone = done & pwrite;
    assign rx_hs = link.tok_valid & rx_free_reg;
    assign pop   = done & ~pwrite & (paddr == C_RXD_OFS)
                   & prdata_reg[RX_FULL_BIT]; // only pop what was shown
    assign ev    = {rx_hs & link.tok_end, rx_hs & ~link.tok_end,
                    req_reg & link.reg_ack};

    // apb answer
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            pready_reg <= 1'b0;
            prdata_reg <= 32'h0;
        end else begin
            pready_reg <= take;
            if (take) begin
                case (paddr)
                    C_CMD_OFS:   prdata_reg <= {req_reg, 22'h0, cmd_wr_reg,
                                                2'h0, cmd_addr_reg};
                    C_WDATA_OFS: prdata_reg <= wdata_reg;
                    C_RDATA_OFS: prdata_reg <= rdata_reg;
                    C_PULSE_OFS: prdata_reg <= {31'h0, samp_reg};
                    C_RXD_OFS:   prdata_reg <= {~rx_free_reg, 22'h0,
                                                rx_end_reg, rx_data_reg};
                    C_RXDST_OFS: prdata_reg <= {8'h0, rx_dest_reg};
                    C_ISTAT_OFS: prdata_reg <= {29'h0, istat_reg};
                    C_IMASK_OFS: prdata_reg <= {29'h0, imask_reg};
                    default:     prdata_reg <= 32'h0;
                endcase
            end
        end
    end

    // device access: held until ack; only 32-bit words exist here
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            req_reg      <= 1'b0;
            cmd_wr_reg   <= 1'b0;
            cmd_addr_reg <= 6'h0;
            wdata_reg    <= 32'h0;
            rdata_reg    <= 32'h0;
        end else begin
            if (wdone && paddr == C_WDATA_OFS) begin
                wdata_reg <= pwdata;
            end
            if (req_reg && link.reg_ack) begin
                req_reg <= 1'b0;
                if (!cmd_wr_reg) begin
                    rdata_reg <= link.reg_rdata;
                end
            end else if (wdone && paddr == C_CMD_OFS && !req_reg
                         && pwdata[CMD_GO_BIT]) begin
                req_reg      <= 1'b1;
                cmd_wr_reg   <= pwdata[CMD_WR_BIT];
                cmd_addr_reg <= pwdata[5:0];
            end
        end
    end

    // software drives the sampling pulse level directly
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            samp_reg <= 1'b0;
        end else if (wdone && paddr == C_PULSE_OFS) begin
            samp_reg <= pwdata[0];
        end
    end

    // one-entry receive holder; stalls the device until popped
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rx_free_reg <= 1'b1;
            rx_data_reg <= 8'h0;
            rx_end_reg  <= 1'b0;
            rx_dest_reg <= 24'h0;
        end else if (rx_hs) begin
            rx_free_reg <= 1'b0;
            rx_data_reg <= link.tok_end ? 8'h0 : link.tok_data;
            rx_end_reg  <= link.tok_end;
            rx_dest_reg <= link.tok_dest;
        end else if (pop) begin
            rx_free_reg <= 1'b1;
        end
    end

    // sticky events, write one to clear; a new event wins
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            istat_reg <= '0;
            imask_reg <= '0;
            irq_reg   <= 1'b0;
        end else begin
            if (wdone && paddr == C_ISTAT_OFS) begin
                istat_reg <= (istat_reg & ~pwdata[INT_W-1:0]) | ev;
            end else begin
                istat_reg <= istat_reg | ev;
            end
            if (wdone && paddr == C_IMASK_OFS) begin
                imask_reg <= pwdata[INT_W-1:0];
            end
            irq_reg <= |(istat_reg & imask_reg);
        end
    end

    assign link.reg_req   = req_reg;
    assign link.reg_wr    = cmd_wr_reg;
    assign link.reg_addr  = cmd_addr_reg;
    assign link.reg_wdata = wdata_reg;
    assign link.samp      = samp_reg;
    assign link.tok_ready = rx_free_reg;
    assign prdata         = prdata_reg;
    assign pready         = pready_reg;
    assign pslverr        = 1'b0;
    assign irq            = irq_reg;
endmodule // asp_ctrl

// File: asp_device.sv
`timescale 1ns/1ps
module asp_device
    import asp_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_b,
    asp_link_if.dev          link,
    input  wire logic [11:0] adc_result,
    output wire logic [2:0]  adc_sel,
    output wire logic        adc_cal,
    output wire logic        adc_on
);
    typedef enum logic [1:0] {ST_IDLE, ST_DATA, ST_END} asp_st_t;

    logic [23:0]       dest_reg [NUM_IN];
    logic [NUM_IN-1:0] in_en_reg;
    logic              gen_en_reg;
    logic              gen_cal_reg;
    logic              drop_reg;
    logic [1:0]        width_reg;
    logic [7:0]        spp_reg;
    logic              ack_reg;
    logic [31:0]       rdata_reg;
    logic              samp_d_reg;
    logic [2:0]        cal_cnt_reg;
    logic [2:0]        sel_reg;
    asp_st_t           st_reg;
    logic [31:0]       sh_reg;
    logic [2:0]        left_reg;
    logic [7:0]        pkt_cnt_reg;
    logic              pend_end_reg;
    logic              tv_reg;
    logic              tend_reg;
    logic [7:0]        tdata_reg;
    logic [23:0]       tdest_reg;

    logic        acc;
    logic        wr;
    logic        rd;
    logic        hit_route;
    logic        hit_gen;
    logic [2:0]  idx;
    logic        rise;
    logic        cal_done;
    logic        conv;
    logic        drop_set;
    logic        tok_hs;
    logic [31:0] fmt;
    logic [2:0]  nbytes;
    logic [7:0]  pkt_cnt_next;

    // index of next enabled input after cur, wrapping; cur if none
    function automatic logic [2:0] nxt(input logic [2:0] cur,
                                       input logic [7:0] en);
        logic [2:0] c;
        nxt = cur;
        for (int i = 7; i >= 1; i--) begin
            c = cur + i[2:0];
            if (en[c]) begin
                nxt = c;
            end
        end
    endfunction

    // one access per request; ack low again before the next is taken
    assign acc       = link.reg_req & ~ack_reg;
    assign wr        = acc & link.reg_wr;
    assign rd        = acc & ~link.reg_wr;
    assign idx       = link.reg_addr[4:2];
    assign hit_route = ~link.reg_addr[5] & (link.reg_addr[1:0] == 2'h0);
    assign hit_gen   = link.reg_addr == GEN_OFS;

    assign rise     = link.samp & ~samp_d_reg;
    assign cal_done = cal_cnt_reg == CAL_PULSES;
    assign conv     = rise & gen_en_reg & cal_done & (|in_en_reg)
                      & (st_reg == ST_IDLE);
    assign drop_set = rise & gen_en_reg & cal_done & (|in_en_reg)
                      & (st_reg != ST_IDLE);
    assign tok_hs   = tv_reg & link.tok_ready;
    assign pkt_cnt_next = pkt_cnt_reg + 8'h01;

    // left aligned formatting; reserved code 2 falls back to 8 bits
    always_comb begin
        fmt    = {adc_result, 20'h0};
        nbytes = 3'h4;
        case (width_reg)
            W_16: begin
                fmt    = {adc_result, 4'h0, 16'h0};
                nbytes = 3'h2;
            end
            W_32: begin
                fmt    = {adc_result, 20'h0};
                nbytes = 3'h4;
            end
            default: begin
                fmt    = {adc_result[11:4], 24'h0};
                nbytes = 3'h1;
            end
        endcase
    end

    // per-input routing registers, frozen while converter runs
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            for (int i = 0; i < NUM_IN; i++) begin
                dest_reg[i] <= 24'h0;
            end
            in_en_reg <= '0;
        end else if (wr && hit_route && !gen_en_reg) begin
            dest_reg[idx]  <= link.reg_wdata[31:ROUTE_DEST_LO];
            in_en_reg[idx] <= link.reg_wdata[ROUTE_EN_BIT];
        end
    end

    // general control fields
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            gen_en_reg  <= 1'b0;
            gen_cal_reg <= 1'b0;
            width_reg   <= WIDTH_RST;
            spp_reg     <= SPP_RST;
        end else if (wr && hit_gen) begin
            gen_en_reg  <= link.reg_wdata[GEN_EN_BIT];
            gen_cal_reg <= link.reg_wdata[GEN_CAL_BIT];
            width_reg   <= link.reg_wdata[GEN_WIDTH_LO +: 2];
            spp_reg     <= link.reg_wdata[GEN_SPP_LO +: 8];
        end
    end

    // dropped flag: a new drop in the read cycle survives the clear
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            drop_reg <= 1'b0;
        end else if (drop_set) begin
            drop_reg <= 1'b1;
        end else if (rd && hit_gen) begin
            drop_reg <= 1'b0;
        end
    end

    // register read data and acknowledge
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ack_reg   <= 1'b0;
            rdata_reg <= 32'h0;
        end else begin
            ack_reg <= acc;
            if (rd) begin
                rdata_reg <= 32'h0;
                if (hit_route) begin
                    rdata_reg <= {dest_reg[idx], 7'h0, in_en_reg[idx]};
                end else if (hit_gen) begin
                    rdata_reg <= {7'h0, drop_reg, 6'h0, width_reg,
                                  spp_reg, 6'h0, gen_cal_reg,
                                  gen_en_reg};
                end
            end
        end
    end

    // calibration pulse count; any disable rearms the six pulses
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            samp_d_reg  <= 1'b0;
            cal_cnt_reg <= 3'h0;
        end else begin
            samp_d_reg <= link.samp;
            if (!gen_en_reg) begin
                cal_cnt_reg <= 3'h0;
            end else if (rise && !cal_done) begin
                cal_cnt_reg <= cal_cnt_reg + 3'h1;
            end
        end
    end

    // input selection: parked on lowest enabled input while disabled
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            sel_reg <= 3'h0;
        end else if (!gen_en_reg) begin
            sel_reg <= nxt(3'h7, in_en_reg);
        end else if (rise) begin
            sel_reg <= nxt(sel_reg, in_en_reg);
        end
    end

    // with a count of zero, packets stay open until a register access
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            pend_end_reg <= 1'b0;
        end else if (acc && spp_reg == 8'h0) begin
            pend_end_reg <= 1'b1;
        end else if (st_reg == ST_END
                     || (st_reg == ST_IDLE && pkt_cnt_reg == 8'h0)) begin
            pend_end_reg <= 1'b0;
        end
    end

    // byte stream: sample bytes msb first, then an end token
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            st_reg      <= ST_IDLE;
            sh_reg      <= 32'h0;
            left_reg    <= 3'h0;
            pkt_cnt_reg <= 8'h0;
            tv_reg      <= 1'b0;
            tend_reg    <= 1'b0;
            tdata_reg   <= 8'h0;
            tdest_reg   <= 24'h0;
        end else begin
            case (st_reg)
                ST_IDLE: begin
                    if (conv) begin
                        st_reg    <= ST_DATA;
                        sh_reg    <= fmt << 8;
                        left_reg  <= nbytes;
                        tdata_reg <= fmt[31:24];
                        tdest_reg <= dest_reg[sel_reg];
                        tv_reg    <= 1'b1;
                    end else if (pend_end_reg && pkt_cnt_reg != 8'h0) begin
                        st_reg   <= ST_END;
                        tv_reg   <= 1'b1;
                        tend_reg <= 1'b1;
                    end
                end
                ST_DATA: begin
                    if (tok_hs && left_reg == 3'h1) begin
                        if (spp_reg != 8'h0 && pkt_cnt_next >= spp_reg) begin
                            st_reg      <= ST_END;
                            tend_reg    <= 1'b1;
                            pkt_cnt_reg <= 8'h0;
                        end else begin
                            st_reg      <= ST_IDLE;
                            tv_reg      <= 1'b0;
                            pkt_cnt_reg <= pkt_cnt_next;
                        end
                    end else if (tok_hs) begin
                        tdata_reg <= sh_reg[31:24];
                        sh_reg    <= sh_reg << 8;
                        left_reg  <= left_reg - 3'h1;
                    end
                end
                ST_END: begin
                    if (tok_hs) begin
                        st_reg      <= ST_IDLE;
                        tv_reg      <= 1'b0;
                        tend_reg    <= 1'b0;
                        pkt_cnt_reg <= 8'h0;
                    end
                end
                default: begin
                    st_reg <= ST_IDLE;
                end
            endcase
        end
    end

    assign link.reg_ack   = ack_reg;
    assign link.reg_rdata = rdata_reg;
    assign link.tok_valid = tv_reg;
    assign link.tok_end   = tend_reg;
    assign link.tok_data  = tdata_reg;
    assign link.tok_dest  = tdest_reg;
    assign adc_sel        = sel_reg;
    assign adc_cal        = gen_cal_reg;
    assign adc_on         = gen_en_reg;
endmodule // asp_device

// File: asp_link_if.sv
`timescale 1ns/1ps
interface asp_link_if;
    logic        reg_req;
    logic        reg_wr;
    logic [5:0]  reg_addr;
    logic [31:0] reg_wdata;
    logic        reg_ack;
    logic [31:0] reg_rdata;
    logic        samp;
    logic        tok_valid;
    logic        tok_end;
    logic [7:0]  tok_data;
    logic [23:0] tok_dest;
    logic        tok_ready;

    modport dev (
        input  reg_req, reg_wr, reg_addr, reg_wdata, samp, tok_ready,
        output reg_ack, reg_rdata, tok_valid, tok_end, tok_data, tok_dest
    );
    modport ctl (
        output reg_req, reg_wr, reg_addr, reg_wdata, samp, tok_ready,
        input  reg_ack, reg_rdata, tok_valid, tok_end, tok_data, tok_dest
    );
endinterface

// File: asp_pkg.sv
package asp_pkg;
    // device register map
    localparam int         NUM_IN        = 8;
    localparam logic [5:0] GEN_OFS       = 6'h20;
    localparam int         ROUTE_DEST_LO = 8;
    localparam int         ROUTE_EN_BIT  = 0;
    localparam int         GEN_DROP_BIT  = 24;
    localparam int         GEN_WIDTH_LO  = 16;
    localparam int         GEN_SPP_LO    = 8;
    localparam int         GEN_CAL_BIT   = 1;
    localparam int         GEN_EN_BIT    = 0;
    localparam logic [1:0] WIDTH_RST     = 2'h1;
    localparam logic [7:0] SPP_RST       = 8'h01;
    localparam logic [1:0] W_8           = 2'h0;
    localparam logic [1:0] W_16          = 2'h1;
    localparam logic [1:0] W_32          = 2'h3;
    localparam logic [2:0] CAL_PULSES    = 3'h6;

    // controller register map (apb byte addresses)
    localparam logic [7:0] C_CMD_OFS   = 8'h00;
    localparam logic [7:0] C_WDATA_OFS = 8'h04;
    localparam logic [7:0] C_RDATA_OFS = 8'h08;
    localparam logic [7:0] C_PULSE_OFS = 8'h0c;
    localparam logic [7:0] C_RXD_OFS   = 8'h10;
    localparam logic [7:0] C_RXDST_OFS = 8'h14;
    localparam logic [7:0] C_ISTAT_OFS = 8'h18;
    localparam logic [7:0] C_IMASK_OFS = 8'h1c;
    localparam int         CMD_GO_BIT  = 31;
    localparam int         CMD_WR_BIT  = 8;
    localparam int         RX_FULL_BIT = 31;
    localparam int         RX_END_BIT  = 8;
    localparam int         INT_DONE    = 0;
    localparam int         INT_RXBYTE  = 1;
    localparam int         INT_RXEND   = 2;
    localparam int         INT_W       = 3;
endpackage
